// ===== core/prs_dev.sv
/*
 * device end: power-up initialization and hardware reset handling
 * of a self-refreshing pseudo-static dram. it times the init wait,
 * refreshes rows while it runs, tracks deep power down and restores
 * the configuration and refresh row counter on a hardware reset.
 * assumes the link pins are synchronous to clk_i, that the host end
 * drives select and reset from flip-flops, and that supply_ok_i is
 * already a clean level from a supply monitor outside this block.
 */
`timescale 1ns/1ns
`include "prs_cfg.svh"

module prs_dev (
    // clock and reset
    // srst_i is the system reset, not the memory's own reset pin
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // link
    prs_link_if.dev                   link,
    // supply monitor and user controls
    input  wire logic                 supply_ok_i,
    input  wire logic                 dpd_enter_i,
    input  wire logic                 cfg_wr_i,
    input  wire logic [15:0]          cfg_wdata_i,
    // status back to the user
    output logic                      ready_o,
    output logic                      refresh_o,
    output logic                      dpd_o,
    output logic                      data_lost_o,
    output logic                      viol_o,
    output logic [15:0]               cfg_o,
    output logic [12:0]               row_o
);
    import prs_pkg::*;

    // ****************************************
    // state
    // ****************************************
    // the whole device state is one packed struct, so the register
    // process below resets and loads every field in one place
    typedef struct packed {
        prs_dev_st_t  st;     // sequencing state
        logic [10:0]  wait_c; // init wait counter
        logic [15:0]  cfg;    // configuration register
        logic [12:0]  row;    // self-refresh row counter
        logic         dpd;    // deep power down
        logic         lost;   // array data may be lost
        logic         viol;   // access seen outside the ready state
        logic         refr;   // refresh strobe this cycle
    } prs_dev_s_t;

    prs_dev_s_t s_q;  // registered state
    prs_dev_s_t s_d;  // next state

    // ****************************************
    // constants and helpers
    // ****************************************
    // last value of the init wait counter; the wait is counted in whole
    // clock cycles, so a slower clock shortens it only by rounding
    localparam logic [10:0] WAIT_LAST = 11'(`PRS_INIT_WAIT_CYC - 1);

    // row counter advance, wraps at the last row
    function automatic logic [12:0] prs_row_next(input logic [12:0] r);
        prs_row_next = (r == `PRS_ROW_LAST) ? `PRS_ROW_DEFAULT : r + 13'h0001;
    endfunction

    // true in the one state that takes bus transactions; used both for
    // the ready output and for flagging a select that came too soon
    function automatic logic prs_accepts(input prs_dev_st_t st);
        prs_accepts = (st == PRS_DS_READY);
    endfunction

    // ****************************************
    // next state
    // ****************************************
    // one combinational pass: the case moves the sequencer, then the
    // reset and supply overrides below win over anything it chose
    always_comb begin
        s_d      = s_q;
        s_d.refr = 1'b0;
        case (s_q.st)
            // waiting for supply and reset high before timing starts
            PRS_DS_POWERUP: begin
                // counter parked at zero so the wait always starts whole
                s_d.wait_c = '0;
                if (supply_ok_i && link.rst_n) begin
                    s_d.st = PRS_DS_INIT;
                end
            end
            // one row per cycle steps through 1500 of the 8192 rows in the wait;
            // busier than a refresh timer, but needs no second counter
            // init wait: refresh every cycle to settle the array
            PRS_DS_INIT: begin
                s_d.refr   = 1'b1;
                s_d.row    = prs_row_next(s_q.row);
                s_d.wait_c = s_q.wait_c + 11'd1;
                // the count is checked against the last value, so the state moves on
                // the edge that ends the last waited cycle
                if (s_q.wait_c == WAIT_LAST) begin
                    s_d.st = PRS_DS_READY;
                end
            end
            // deep power down stops refresh and ignores config writes;
            // only a hardware reset or the system reset srst_i brings the device back out of it
            // normal operation, hidden self-refresh keeps running
            PRS_DS_READY: begin
                if (!s_q.dpd) begin
                    s_d.refr = 1'b1;
                    s_d.row  = prs_row_next(s_q.row);
                end
                if (dpd_enter_i) begin
                    s_d.dpd = 1'b1;
                end
                if (cfg_wr_i && !s_q.dpd) begin
                    s_d.cfg = cfg_wdata_i;
                end
            end
            // reset released: back to standby, refresh resumes
            PRS_DS_RESET: begin
                // ready is entered on the edge after reset rises, refresh on the next edge
                s_d.st = PRS_DS_READY;
            end
            default: begin
                // unused encodings fall back to power-up, the safe side
                s_d.st = PRS_DS_POWERUP;
            end
        endcase
        // an access outside ready is flagged; stays sticky
        // a debug aid only: the access itself is not blocked
        if (!link.cs_n && !prs_accepts(s_q.st)) begin
            s_d.viol = 1'b1;
        end
        // hardware reset: defaults, row counter home, no refresh
        // taken on every cycle that reset stays low, so the defaults
        // hold and refresh stays stopped for the whole pulse
        if (!link.rst_n) begin
            s_d.cfg  = `PRS_CFG_DEFAULT;
            s_d.row  = `PRS_ROW_DEFAULT;
            s_d.refr = 1'b0;
            s_d.dpd  = 1'b0;
            // once ready, the array may hold data that the stopped
            // refresh now puts at risk; before that nothing can be lost
            if (s_q.st == PRS_DS_READY || s_q.st == PRS_DS_RESET) begin
                s_d.st   = PRS_DS_RESET;
                s_d.lost = 1'b1;
            end else begin
                // still powering up: postpone the init wait
                // no data is at risk yet, so the lost flag stays clear
                s_d.st = PRS_DS_POWERUP;
            end
        end
        // losing the supply restarts the sequencer and the init wait counter
        // it wins over reset so a brown-out always re-runs the init wait
        if (!supply_ok_i) begin
            s_d.st     = PRS_DS_POWERUP;
            s_d.wait_c = '0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // plain synchronous reset; every field takes its reset value here,
    // so nothing is left unknown when the link first moves
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q.st     <= PRS_DS_POWERUP;
            s_q.wait_c <= '0;
            s_q.cfg    <= `PRS_CFG_DEFAULT;
            s_q.row    <= `PRS_ROW_DEFAULT;
            s_q.dpd    <= 1'b0;
            s_q.lost   <= 1'b0;
            s_q.viol   <= 1'b0;
            s_q.refr   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // data outputs come straight from flip-flops; ready is decoded from
    // registered state only, so it never glitches on a link input
    assign ready_o     = prs_accepts(s_q.st) && !s_q.dpd;
    assign refresh_o   = s_q.refr;
    assign dpd_o       = s_q.dpd;
    assign data_lost_o = s_q.lost;
    assign viol_o      = s_q.viol;
    assign cfg_o       = s_q.cfg;
    // row lets a test watch the refresh sweep and its return home
    assign row_o       = s_q.row;
endmodule

// ===== pkg/prs_cfg.svh
/*
 * timing constants and reset values for the power-up and reset sequencer
 * pair. assumes a 10 MHz system clock (100 ns period).
 */
`ifndef PRS_CFG_SVH
`define PRS_CFG_SVH

// clock period in ns
`define PRS_CLK_NS              100
// power-up initialization wait, us
`define PRS_INIT_WAIT_US        150
`define PRS_INIT_WAIT_CYC       ((`PRS_INIT_WAIT_US * 1000) / `PRS_CLK_NS)
// least reset pulse, ns (rounded up)
`define PRS_RST_PULSE_NS        200
`define PRS_RST_PULSE_CYC \
    ((`PRS_RST_PULSE_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
// least reset release to select, ns
`define PRS_REL_SEL_NS          200
`define PRS_REL_SEL_CYC \
    ((`PRS_REL_SEL_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
// least reset assert to select, ns
`define PRS_ASR_SEL_NS          400
`define PRS_ASR_SEL_CYC \
    ((`PRS_ASR_SEL_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
// least deselect gap, ns (at least one cycle)
`define PRS_GAP_NS              10
`define PRS_GAP_CYC \
    ((`PRS_GAP_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
// reset values
`define PRS_CFG_DEFAULT         16'h8F1F
`define PRS_ROW_DEFAULT         13'h0000
`define PRS_ROW_LAST            13'h1FFF

`endif

// ===== pkg/prs_pkg.sv
/*
 * types shared by both ends of the power-up and reset sequencer.
 * assumes prs_cfg.svh is on the include path.
 */
package prs_pkg;
    // device state, gray along power-up -> init -> ready
    typedef enum logic [1:0] {
        PRS_DS_POWERUP = 2'b00,
        PRS_DS_INIT    = 2'b01,
        PRS_DS_READY   = 2'b11,
        PRS_DS_RESET   = 2'b10
    } prs_dev_st_t;
    // host state, gray along the path
    typedef enum logic [2:0] {
        PRS_HS_IDLE  = 3'b000,
        PRS_HS_PULSE = 3'b001,
        PRS_HS_HOLD  = 3'b011,
        PRS_HS_GAP   = 3'b010,
        PRS_HS_READY = 3'b110,
        PRS_HS_BUSY  = 3'b111
    } prs_host_st_t;
endpackage

// ===== pkg/prs_link_if.sv
/*
 * link between host sequencer and memory device: select and reset,
 * both active low, plus the host's transfer-in-progress flag for the checker.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/1ns
interface prs_link_if;
    logic cs_n;      // chip select, low selects
    logic rst_n;     // hardware reset, low resets
    logic xfer;      // host marks a bus transaction in progress
    modport dev  (input cs_n, input rst_n, input xfer);
    modport host (output cs_n, output rst_n, output xfer);
endinterface

// ===== core/prs_host.sv
/*
 * host end: drives select and reset to the memory and spaces them
 * by the required minimum delays.
 * assumes one clock at 10 MHz shared with the device end.
 */
`timescale 1ns/1ns
`include "prs_cfg.svh"

module prs_host (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    // link
    prs_link_if.host                  link,
    // user side
    input  wire logic                 supply_ok_i,
    input  wire logic                 rst_req_i,
    input  wire logic                 xfer_req_i,
    input  wire logic                 xfer_done_i,
    output logic                      xfer_ack_o,
    output logic                      ready_o
);
    import prs_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        prs_host_st_t st;   // sequencing state
        logic [10:0]  cnt;  // delay counter
        logic [10:0]  asr;  // cycles since reset fell
        logic         cs_n; // select pin
        logic         rst_n;// reset pin
    } prs_host_s_t;

    prs_host_s_t s_q;  // registered state
    prs_host_s_t s_d;  // next state

    localparam logic [10:0] INIT_CYC  = 11'(`PRS_INIT_WAIT_CYC);
    localparam logic [10:0] PULSE_CYC = 11'(`PRS_RST_PULSE_CYC);
    localparam logic [10:0] REL_CYC   = 11'(`PRS_REL_SEL_CYC);
    localparam logic [10:0] ASR_CYC   = 11'(`PRS_ASR_SEL_CYC);
    localparam logic [10:0] GAP_CYC   = 11'(`PRS_GAP_CYC);

    // saturating increment, shared by both counters
    function automatic logic [10:0] prs_sat_inc(input logic [10:0] c);
        prs_sat_inc = (c == 11'h7FF) ? c : c + 11'd1;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d     = s_q;
        s_d.cnt = prs_sat_inc(s_q.cnt);
        s_d.asr = prs_sat_inc(s_q.asr);
        case (s_q.st)
            // deselected until the supply is up, then the init wait
            PRS_HS_IDLE: begin
                s_d.cs_n  = 1'b1;
                s_d.rst_n = 1'b1;
                if (!supply_ok_i) begin
                    s_d.cnt = '0;
                end else if (s_q.cnt >= INIT_CYC) begin
                    s_d.st  = PRS_HS_GAP;
                    s_d.cnt = '0;
                end
            end
            // reset held low for the least pulse width
            PRS_HS_PULSE: begin
                s_d.rst_n = 1'b0;
                if (s_q.cnt >= PULSE_CYC - 11'd1 && !rst_req_i) begin
                    s_d.st    = PRS_HS_HOLD;
                    s_d.rst_n = 1'b1;
                    s_d.cnt   = '0;
                end
            end
            // release-to-select and assert-to-select both met
            PRS_HS_HOLD: begin
                if (s_q.cnt >= REL_CYC - 11'd1
                    && s_q.asr >= ASR_CYC - 11'd1) begin
                    s_d.st  = PRS_HS_GAP;
                    s_d.cnt = '0;
                end
            end
            // select high at least the deselect gap
            PRS_HS_GAP: begin
                s_d.cs_n = 1'b1;
                if (s_q.cnt >= GAP_CYC - 11'd1) begin
                    s_d.st = PRS_HS_READY;
                end
            end
            // accept a transfer request
            PRS_HS_READY: begin
                if (xfer_req_i) begin
                    s_d.st   = PRS_HS_BUSY;
                    s_d.cs_n = 1'b0;
                end
            end
            // transfer running until the user ends it
            PRS_HS_BUSY: begin
                if (xfer_done_i) begin
                    s_d.st   = PRS_HS_GAP;
                    s_d.cs_n = 1'b1;
                    s_d.cnt  = '0;
                end
            end
            default: begin
                s_d.st = PRS_HS_IDLE;
            end
        endcase
        // reset request outside power-up: deselect, start the pulse
        if (rst_req_i && s_q.st != PRS_HS_IDLE
            && s_q.st != PRS_HS_PULSE) begin
            s_d.st    = PRS_HS_PULSE;
            s_d.cs_n  = 1'b1;
            s_d.rst_n = 1'b0;
            s_d.cnt   = '0;
            s_d.asr   = '0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q.st    <= PRS_HS_IDLE;
            s_q.cnt   <= '0;
            s_q.asr   <= '0;
            s_q.cs_n  <= 1'b1;
            s_q.rst_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.cs_n  = s_q.cs_n;
    assign link.rst_n = s_q.rst_n;
    assign link.xfer  = (s_q.st == PRS_HS_BUSY);
    // handshake outputs are combinational of registered state, ack also of the request
    assign xfer_ack_o = (s_q.st == PRS_HS_READY) && xfer_req_i;
    assign ready_o    = (s_q.st == PRS_HS_READY);
endmodule

// ===== tb/prs_checker.sv
/*
 * checker on the select and reset link between the two ends.
 * assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ns
`include "prs_cfg.svh"

module prs_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // link
    input wire logic cs_n,
    input wire logic rst_n,
    input wire logic xfer
);
    // ****************
    // helper and rules
    // ****************
    localparam int INIT_MIN = `PRS_INIT_WAIT_CYC;
    logic [11:0] up_q;  // cycles since reset; saturates, never wraps
    // age counter so a select can be tied to the init wait
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            up_q <= '0;
        end else if (up_q != 12'hFFF) begin
            up_q <= up_q + 12'h001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    reset_idle_a: assert property ($fell(srst_i) |-> cs_n && rst_n)
        else $error("link not idle after reset");
    init_wait_a: assert property (!cs_n |-> up_q >= INIT_MIN)
        else $error("select during init wait");
    init_xfer_a: assert property (xfer |-> up_q >= INIT_MIN)
        else $error("transfer during init wait");
    xfer_sel_a: assert property (xfer == !cs_n)
        else $error("transfer flag and select disagree");
    pulse_min_a: assert property ($fell(rst_n) |-> ##1 !rst_n)
        else $error("reset pulse too short");
    reset_quiet_a: assert property (!rst_n |-> cs_n && !xfer)
        else $error("bus busy while reset low");
    release_sel_a: assert property ($rose(rst_n) |-> cs_n [*2])
        else $error("select too soon after release");
    assert_sel_a: assert property ($fell(rst_n) |-> cs_n [*4])
        else $error("select too soon after reset fall");
    desel_gap_a: assert property ($rose(cs_n) |=> cs_n)
        else $error("deselect gap missing");
    cover property ($fell(rst_n));
    cover property ($fell(cs_n) ##[1:20] $rose(cs_n));
    cover property ($rose(rst_n) ##[2:20] $fell(cs_n));
endmodule

// ===== tb/tb_psram_power_up_reset_seq.sv
/*
 * bench: host and device ends on one link, plus a second device end
 * whose link the bench drives by hand to break host rules.
 * assumes prs_cfg.svh on the include path and a 10 MHz clock.
 */
`timescale 1ns/1ns
`include "prs_cfg.svh"

module tb_psram_power_up_reset_seq;
    // ****************
    // signals and ends
    // ****************
    typedef struct {
        logic        dpd;  // enter deep power down first
        logic [15:0] wd;   // config write data
        logic [15:0] cfg;  // config expected
        logic        rdy;  // ready expected
    } prs_row_t;
    prs_row_t    rows [4] = '{'{1'b0, 16'h1234, 16'h1234, 1'b1},
        '{1'b0, 16'hFFFF, 16'hFFFF, 1'b1}, '{1'b0, 16'h0000, 16'h0000, 1'b1},
        '{1'b1, 16'hA5A5, 16'h0000, 1'b0}};
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        sup = 1'b0;
    logic        dpd = 1'b0;
    logic        wr = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic        rq = 1'b0;
    logic        xr = 1'b0;
    logic        xd = 1'b0;
    logic        d_rdy, d_ref, d_dpd, d_lost, d_viol, h_ack, h_rdy;
    logic        b_rdy, b_lost, b_viol;
    logic [15:0] d_cfg;
    logic [12:0] d_row;
    int          failures = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          n;
    prs_link_if  lk ();
    prs_link_if  lk_b ();  // driven by the bench, not by a host
    prs_host u_prs_host (.clk_i(clk_i), .srst_i(srst_i), .link(lk.host),
        .supply_ok_i(sup), .rst_req_i(rq), .xfer_req_i(xr),
        .xfer_done_i(xd), .xfer_ack_o(h_ack), .ready_o(h_rdy));
    prs_dev u_prs_dev (.clk_i(clk_i), .srst_i(srst_i), .link(lk.dev),
        .supply_ok_i(sup), .dpd_enter_i(dpd), .cfg_wr_i(wr),
        .cfg_wdata_i(wd), .ready_o(d_rdy), .refresh_o(d_ref), .dpd_o(d_dpd),
        .data_lost_o(d_lost), .viol_o(d_viol), .cfg_o(d_cfg), .row_o(d_row));
    prs_dev u_prs_dev_b (.clk_i(clk_i), .srst_i(srst_i), .link(lk_b.dev),
        .supply_ok_i(sup), .dpd_enter_i(1'b0), .cfg_wr_i(1'b0),
        .cfg_wdata_i(16'h0000), .ready_o(b_rdy), .refresh_o(), .dpd_o(),
        .data_lost_o(b_lost), .viol_o(b_viol), .cfg_o(), .row_o());
    prs_checker u_prs_checker (.clk_i(clk_i), .srst_i(srst_i),
        .cs_n(lk.cs_n), .rst_n(lk.rst_n), .xfer(lk.xfer));
    // ****************
    // clock, tasks, run
    // ****************
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // hang guard, well above the two init waits
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one transfer: request, hold select, then finish
    task automatic xfer_once();
        n = 0;
        xr <= 1'b1;
        while (h_ack !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("ack", h_ack, 1'b1);
        xr <= 1'b0;
        tick(3);
        chk("cs_n", lk.cs_n, 1'b0);
        xd <= 1'b1;
        tick(1);
        xd <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        lk_b.cs_n = 1'b1;
        lk_b.rst_n = 1'b0;  // held low through power-up
        lk_b.xfer = 1'b0;
        tick(10);
        srst_i <= 1'b0;
        sup <= 1'b1;
        chk("cfg", d_cfg, `PRS_CFG_DEFAULT);
        chk("row", d_row, `PRS_ROW_DEFAULT);
        chk("cs_n", lk.cs_n, 1'b1);
        tick(50);
        chk("refresh", d_ref, 1'b1);
        lk_b.cs_n <= 1'b0;  // select the second end far too early
        tick(1);
        lk_b.cs_n <= 1'b1;
        tick(49);
        lk_b.rst_n <= 1'b1;
        tick(`PRS_INIT_WAIT_CYC - 110);
        chk("ready", d_rdy, 1'b0);
        tick(20);
        chk("ready", d_rdy, 1'b1);
        chk("host_ready", h_rdy, 1'b1);
        n = 0;
        while (b_rdy !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        chk("b_wait", 16'(n > 80 && n < 200), 16'h0001);
        chk("b_lost", b_lost, 1'b0);
        chk("b_viol", b_viol, 1'b1);
        // config writes and transfers; last row is in deep power down
        foreach (rows[i]) begin
            dpd <= rows[i].dpd;
            tick(2);
            dpd <= 1'b0;
            wr <= 1'b1;
            wd <= rows[i].wd;
            tick(1);
            wr <= 1'b0;
            tick(2);
            chk("cfg", d_cfg, rows[i].cfg);
            chk("ready", d_rdy, rows[i].rdy);
            if (!rows[i].dpd) begin
                xfer_once();
                xfer_once();
            end
        end
        chk("dpd", d_dpd, 1'b1);
        rq <= 1'b1;
        tick(1);
        rq <= 1'b0;
        n = 0;
        while (lk.rst_n !== 1'b0 && n < 10) begin
            tick(1);
            n++;
        end
        tick(1);
        chk("ready", d_rdy, 1'b0);
        chk("cfg", d_cfg, `PRS_CFG_DEFAULT);
        chk("refresh", d_ref, 1'b0);
        chk("dpd", d_dpd, 1'b0);
        chk("row", d_row, `PRS_ROW_DEFAULT);
        chk("lost", d_lost, 1'b1);
        tick(10);
        chk("ready", d_rdy, 1'b1);
        chk("refresh", d_ref, 1'b1);
        // long request stretches the pulse
        rq <= 1'b1;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            tick(1);
            if (i == 5) rq <= 1'b0;
            if (i == 4) chk("refresh_low", d_ref, 1'b0);
            if (i == 4) chk("row_home", d_row, `PRS_ROW_DEFAULT);
            if (lk.rst_n === 1'b0) n++;
        end
        chk("stretch", 16'(n >= 6 && n <= 8), 16'h0001);
        chk("lost", d_lost, 1'b1);
        xfer_once();
        tick(5);
        chk("viol", d_viol, 1'b0);
        test_done();
    end
endmodule
